// ==== rtl/flsc_flash_ctl.sv ====
`timescale 1ns/100ps
module flsc_flash_ctl #(
  parameter int unsigned LONG_CYC  = flsc_pkg::SAFE_LONG_CYC,
  parameter int unsigned SHORT_CYC = flsc_pkg::SAFE_SHORT_CYC
) (
  input  wire logic       clk,   // system clock
  input  wire logic       rst_n, // async reset, active low
  flsc_flash_if.ctl       fl     // flash control group
);

  localparam logic [flsc_pkg::SAFE_CNT_W-1:0] LIM_LONG  =
    flsc_pkg::SAFE_CNT_W'(LONG_CYC - 1);
  localparam logic [flsc_pkg::SAFE_CNT_W-1:0] LIM_SHORT =
    flsc_pkg::SAFE_CNT_W'(SHORT_CYC - 1);
  localparam logic [flsc_pkg::SAFE_CNT_W-1:0] CNT_ONE   =
    flsc_pkg::SAFE_CNT_W'(1);

  flsc_pkg::flsc_flash_st_t              st_q, st_d;
  logic [flsc_pkg::SAFE_CNT_W-1:0]       cnt_q, cnt_d;
  logic [flsc_pkg::SAFE_CNT_W-1:0]       lim;
  logic                                  trig_q;
  logic                                  to_q, to_d;
  logic                                  torch_q, torch_d;
  logic                                  rise;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    // R2: low picks the long limit
    lim     = fl.safe_short ? LIM_SHORT : LIM_LONG;
    rise    = fl.trig & ~trig_q;
    st_d    = st_q;
    cnt_d   = cnt_q;
    to_d    = to_q;
    // R3: torch only while arm is clear
    torch_d = fl.torch & ~fl.arm;
    if (!fl.arm) begin
      // R15: disarm clears counter
      st_d  = flsc_pkg::FLSC_FL_OFF;
      cnt_d = '0;
      to_d  = 1'b0;
    end else begin
      unique case (st_q)
        flsc_pkg::FLSC_FL_OFF: begin
          // R4: rising edge engages
          if (rise) begin
            st_d  = flsc_pkg::FLSC_FL_ON;
            cnt_d = '0;
            to_d  = 1'b0;
          end
        end
        flsc_pkg::FLSC_FL_ON: begin
          if (!fl.trig) begin
            // R4: falling edge disengages
            st_d  = flsc_pkg::FLSC_FL_OFF;
            cnt_d = '0;
          end else if (cnt_q >= lim) begin
            // R1: cutoff, also if limit shortened mid-flash
            st_d  = flsc_pkg::FLSC_FL_OFF;
            cnt_d = '0;
            to_d  = 1'b1;
          end else begin
            cnt_d = cnt_q + CNT_ONE;
          end
        end
      endcase
      // R15: timeout held until trigger drops
      if (!fl.trig) begin
        to_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= flsc_pkg::FLSC_FL_OFF;
      cnt_q   <= '0;
      trig_q  <= 1'b0;
      to_q    <= 1'b0;
      torch_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      trig_q  <= fl.trig;
      to_q    <= to_d;
      torch_q <= torch_d;
    end
  end

  // R6: torch selects low current, flash high
  assign fl.torch_on  = torch_q;
  assign fl.flash_on  = (st_q == flsc_pkg::FLSC_FL_ON);
  assign fl.timed_out = to_q;

endmodule

// ==== rtl/flsc_flash_if.sv ====
`timescale 1ns/100ps
interface flsc_flash_if;
  logic arm;
  logic torch;
  logic trig;
  logic safe_short;
  logic torch_on;
  logic flash_on;
  logic timed_out;

  modport ctl (input arm, input torch, input trig, input safe_short,
               output torch_on, output flash_on, output timed_out);
  modport top (output arm, output torch, output trig, output safe_short,
               input torch_on, input flash_on, input timed_out);
endinterface

// ==== rtl/flsc_pkg.sv ====
package flsc_pkg;

  // register map, byte addresses on the parallel register port
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_BRT1  = 8'h01;
  localparam logic [7:0] ADDR_BRT2  = 8'h02;
  localparam logic [7:0] ADDR_BRT3  = 8'h03;
  localparam logic [7:0] ADDR_BRT4  = 8'h04;
  localparam logic [7:0] ADDR_AUDIO = 8'h05;
  localparam logic [7:0] ADDR_STAT  = 8'h06;

  localparam int NUM_SINKS = 4;
  localparam int CODE_W    = 8;

  // control register fields
  localparam int CTRL_SINK_LSB = 0;
  localparam int CTRL_TORCH    = 4;
  localparam int CTRL_ARM      = 5;
  localparam int CTRL_TRIG     = 6;
  localparam int CTRL_SAFE     = 7;

  localparam int AUDIO_EN_BIT  = 0;

  localparam int STAT_TORCH    = 0;
  localparam int STAT_FLASH    = 1;
  localparam int STAT_TIMEOUT  = 2;

  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] BRT_RST   = 8'h00;
  localparam logic [7:0] AUDIO_RST = 8'h00;
  localparam logic [7:0] RD_ZERO   = 8'h00;

  // safety limits
  localparam int unsigned CLK_KHZ       = 100000;
  localparam int unsigned SAFE_LONG_MS  = 2000;
  localparam int unsigned SAFE_SHORT_MS = 1000;
  localparam int unsigned SAFE_LONG_CYC  = SAFE_LONG_MS * CLK_KHZ;
  localparam int unsigned SAFE_SHORT_CYC = SAFE_SHORT_MS * CLK_KHZ;
  localparam int SAFE_CNT_W = 28;

  typedef enum logic {
    FLSC_FL_OFF,
    FLSC_FL_ON
  } flsc_flash_st_t;

endpackage

// ==== rtl/flsc_sinks.sv ====
`timescale 1ns/100ps
module flsc_sinks (
  input  wire logic                                     clk,         // system clock
  input  wire logic                                     rst_n,       // async reset
  input  wire logic [flsc_pkg::NUM_SINKS-1:0]           sink_on,     // direct on/off
  input  wire logic [flsc_pkg::NUM_SINKS-1:0][7:0]      code,        // brightness codes
  input  wire logic                                     audio_en,    // audio drives sink 1
  input  wire logic [7:0]                               audio_level, // audio level
  output logic      [flsc_pkg::NUM_SINKS-1:0][7:0]      level        // dac codes
);

  logic [flsc_pkg::NUM_SINKS-1:0][7:0] level_d;

  // R11: an off sink stays dark
  function automatic logic [7:0] gate(input logic on, input logic [7:0] c);
    return on ? c : 8'h00;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < flsc_pkg::NUM_SINKS; i++) begin
      // R12: code passes straight to linear dac
      level_d[i] = gate(sink_on[i], code[i]);
    end
    // R13: first sink may follow audio
    if (audio_en) begin
      level_d[0] = gate(sink_on[0], audio_level);
    end
  end

  // R9: four independent sink levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= '0;
    end else begin
      level <= level_d;
    end
  end

endmodule

// ==== rtl/flsc_top.sv ====
// Functional notes
// R1: safety counter cuts a stuck flash
// R2: selection bit low two seconds, high one
// R3: arm clear: off, or torch if enabled
// R4: trigger rise engages, fall disengages flash
// R5: trigger from register bit or pin
// R6: torch low current, flash high current
// R7: host writes arm and trigger together
// R8: host clears trigger after a timeout
// R9: four independent constant current sinks
// R10: control register holds four on bits
// R11: off sink stays dark whatever code
// R12: eight-bit code maps linearly to current
// R13: first sink may follow audio level
// R14: audio mode ignores first brightness writes
// R15: timeout holds until trigger falls, rises; code clears it on the fall
`timescale 1ns/100ps
module flsc_top #(
  parameter int unsigned SAFE_LONG_CYC  = flsc_pkg::SAFE_LONG_CYC,  // 2.0 s in cycles
  parameter int unsigned SAFE_SHORT_CYC = flsc_pkg::SAFE_SHORT_CYC  // 1.0 s in cycles
) (
  input  wire logic                                clk,            // 100 MHz clock
  input  wire logic                                rst_n,          // async reset
  input  wire logic [7:0]                          reg_addr,       // register address
  input  wire logic [7:0]                          reg_wdata,      // write data
  input  wire logic                                reg_wr,         // write strobe
  output logic      [7:0]                          reg_rdata,      // read data, 1 cycle
  input  wire logic                                flash_sync_pin, // external trigger
  input  wire logic [7:0]                          audio_level,    // audio sync level
  output logic                                     torch_on,       // low current sink
  output logic                                     flash_on,       // high current sink
  output logic      [flsc_pkg::NUM_SINKS-1:0][7:0] sink_level      // sink dac codes
);

  logic [7:0]                            ctrl_q, ctrl_d;
  logic [flsc_pkg::NUM_SINKS-1:0][7:0]   brt_q, brt_d;
  logic [7:0]                            audio_q, audio_d;
  logic [7:0]                            rdata_d;
  logic [7:0]                            stat;
  logic                                  pin_s1_q, pin_s2_q;
  logic                                  audio_en;

  flsc_flash_if fl ();

  //////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= flash_sync_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign audio_en = audio_q[flsc_pkg::AUDIO_EN_BIT];

  always_comb begin
    stat                         = 8'h00;
    stat[flsc_pkg::STAT_TORCH]   = fl.torch_on;
    stat[flsc_pkg::STAT_FLASH]   = fl.flash_on;
    stat[flsc_pkg::STAT_TIMEOUT] = fl.timed_out;
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    brt_d   = brt_q;
    audio_d = audio_q;
    if (reg_wr) begin
      unique case (reg_addr)
        // R10: on bits in control register
        flsc_pkg::ADDR_CTRL:  ctrl_d = reg_wdata;
        // R14: first brightness locked in audio mode
        flsc_pkg::ADDR_BRT1:  brt_d[0] = audio_en ? brt_q[0] : reg_wdata;
        flsc_pkg::ADDR_BRT2:  brt_d[1] = reg_wdata;
        flsc_pkg::ADDR_BRT3:  brt_d[2] = reg_wdata;
        flsc_pkg::ADDR_BRT4:  brt_d[3] = reg_wdata;
        flsc_pkg::ADDR_AUDIO: audio_d = reg_wdata;
        default: ;
      endcase
    end
    unique case (reg_addr)
      flsc_pkg::ADDR_CTRL:  rdata_d = ctrl_q;
      flsc_pkg::ADDR_BRT1:  rdata_d = brt_q[0];
      flsc_pkg::ADDR_BRT2:  rdata_d = brt_q[1];
      flsc_pkg::ADDR_BRT3:  rdata_d = brt_q[2];
      flsc_pkg::ADDR_BRT4:  rdata_d = brt_q[3];
      flsc_pkg::ADDR_AUDIO: rdata_d = audio_q;
      flsc_pkg::ADDR_STAT:  rdata_d = stat;
      default:              rdata_d = flsc_pkg::RD_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= flsc_pkg::CTRL_RST;
      brt_q     <= {flsc_pkg::NUM_SINKS{flsc_pkg::BRT_RST}};
      audio_q   <= flsc_pkg::AUDIO_RST;
      reg_rdata <= flsc_pkg::RD_ZERO;
    end else begin
      ctrl_q    <= ctrl_d;
      brt_q     <= brt_d;
      audio_q   <= audio_d;
      reg_rdata <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign fl.arm        = ctrl_q[flsc_pkg::CTRL_ARM];
  assign fl.torch      = ctrl_q[flsc_pkg::CTRL_TORCH];
  assign fl.safe_short = ctrl_q[flsc_pkg::CTRL_SAFE];
  // R5: software bit or hardware pin
  assign fl.trig       = ctrl_q[flsc_pkg::CTRL_TRIG] | pin_s2_q;

  flsc_flash_ctl #(
    .LONG_CYC  (SAFE_LONG_CYC),
    .SHORT_CYC (SAFE_SHORT_CYC)
  ) u_flash (
    .clk   (clk),
    .rst_n (rst_n),
    .fl    (fl)
  );

  assign torch_on = fl.torch_on;
  assign flash_on = fl.flash_on;

  flsc_sinks u_sinks (
    .clk         (clk),
    .rst_n       (rst_n),
    .sink_on     (ctrl_q[flsc_pkg::CTRL_SINK_LSB +: flsc_pkg::NUM_SINKS]),
    .code        (brt_q),
    .audio_en    (audio_en),
    .audio_level (audio_level),
    .level       (sink_level)
  );

endmodule

// ==== tb/flsc_camera.sv ====
`timescale 1ns/100ps
module flsc_camera (
  input wire logic       clk,  // clock
  input wire logic       fire, // start a sync pulse
  input wire logic [7:0] len,  // pulse length in cycles
  output logic           pin   // sync pin to the device
);
  logic [7:0] n_q   = 8'h00;
  logic       pin_q = 1'b0;
  always @(posedge clk) begin
    if (fire) n_q <= len;
    else if (n_q != 8'h00) n_q <= n_q - 8'h01;
  end
  // hardware trigger pulse, moves off the sampling edge
  always @(negedge clk) begin
    pin_q <= (n_q != 8'h00);
  end
  assign pin = pin_q;
endmodule

// ==== tb/flsc_checker.sv ====
`timescale 1ns/100ps
module flsc_checker #(
  parameter int unsigned SAFE_LONG_CYC  = 40,
  parameter int unsigned SAFE_SHORT_CYC = 20
) (
  input wire logic                                clk,
  input wire logic                                rst_n,
  input wire logic [7:0]                          reg_addr,
  input wire logic [7:0]                          reg_wdata,
  input wire logic                                reg_wr,
  input wire logic [7:0]                          reg_rdata,
  input wire logic                                flash_sync_pin,
  input wire logic                                torch_on,
  input wire logic                                flash_on,
  input wire logic [flsc_pkg::NUM_SINKS-1:0][7:0] sink_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] cnt_q, cnt_d;
  logic        safe_q, safe_d;
  always_comb begin
    cnt_d  = flash_on ? cnt_q + 32'h1 : 32'h0;
    safe_d = (reg_wr && reg_addr == 8'h00) ? reg_wdata[7] : safe_q;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 32'h0;
      safe_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      safe_q <= safe_d;
    end
  end
  sequence ctrl_wr(m);
    reg_wr && reg_addr == 8'h00 && reg_wdata[5:4] == m;
  endsequence
  sequence arm_wr;
    reg_wr && reg_addr == 8'h00 && reg_wdata[5];
  endsequence
  torch_excl_a: assert property (!(torch_on && flash_on))
    else $error("torch and flash on together");
  flash_limit_a: assert property (flash_on |-> cnt_q < SAFE_LONG_CYC)
    else $error("flash longer than long limit");
  short_limit_a: assert property (flash_on && safe_q && $past(safe_q)
    |-> cnt_q < SAFE_SHORT_CYC) else $error("flash longer than short limit");
  torch_mode_a: assert property (ctrl_wr(2'b01) |-> ##2 torch_on)
    else $error("torch not on");
  all_off_a: assert property (ctrl_wr(2'b00) |-> ##2 !torch_on && !flash_on)
    else $error("output not off");
  arm_cancel_a: assert property (arm_wr |-> ##2 !torch_on)
    else $error("torch kept with arm");
  sinks_off_a: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[3:0] == 4'h0
    |-> ##2 sink_level == '0) else $error("sink lit while off");
  brt_back_a: assert property (reg_wr && reg_addr == 8'h03 ##1 !reg_wr && reg_addr == 8'h03
    |-> ##1 reg_rdata == $past(reg_wdata, 2)) else $error("brightness readback");
  flash_rel_a: assert property (reg_wr && reg_addr == 8'h00 && !reg_wdata[6]
    && !flash_sync_pin && !$past(flash_sync_pin) && !$past(flash_sync_pin, 2)
    |-> ##2 !flash_on) else $error("flash not released");
endmodule
bind flsc_top flsc_checker #(.SAFE_LONG_CYC(SAFE_LONG_CYC), .SAFE_SHORT_CYC(SAFE_SHORT_CYC))
  u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata), .flash_sync_pin(flash_sync_pin),
  .torch_on(torch_on), .flash_on(flash_on), .sink_level(sink_level));

// ==== tb/flsc_top_test.sv ====
`timescale 1ns/100ps
module flsc_top_test;
  localparam int LC = 40;
  localparam int SC = 20;
  logic            clk, rst_n, reg_wr, pin, fire, torch_on, flash_on;
  logic [7:0]      addr, wdata, rdata, audio, len, on;
  logic [3:0][7:0] lvl;
  logic [7:0]      code [4];
  int              num_errors, n_compared, seed, i, k, n;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  flsc_camera u_cam (.clk(clk), .fire(fire), .len(len), .pin(pin));
  flsc_top #(.SAFE_LONG_CYC(LC), .SAFE_SHORT_CYC(SC)) u_dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rdata(rdata),
    .flash_sync_pin(pin), .audio_level(audio), .torch_on(torch_on),
    .flash_on(flash_on), .sink_level(lvl));
  function automatic logic [7:0] exp_lvl(input logic en, input logic [7:0] c);
    return en ? c : 8'h00;
  endfunction
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a; wdata = d; reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk("read", e, rdata);
  endtask
  // flash length in cycles, bounded waits
  task automatic flen(output int c);
    int w;
    c = 0; w = 0;
    while (!flash_on && w < 100) begin @(negedge clk); w++; end
    while (flash_on && c < 200) begin c++; @(negedge clk); end
  endtask
  task automatic stop_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    stop_test;
  end
  initial begin
    seed = 28; rst_n = 1'b0; reg_wr = 1'b0; addr = 8'h00; wdata = 8'h00;
    audio = 8'h00; fire = 1'b0; len = 8'h00; num_errors = 0; n_compared = 0;
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    for (i = 0; i < 8; i++) rd(8'(i), 8'h00);
    chk("sink", 8'h00, lvl[0] | lvl[1] | lvl[2] | lvl[3]);
    // corner codes first, then random codes and gates
    for (k = 0; k < 6; k++) begin
      on = (k < 2) ? 8'h0f : (k == 2) ? 8'h00 : 8'h0f & 8'($random(seed));
      for (i = 0; i < 4; i++) begin
        code[i] = (k == 0 || k == 2) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
        wr(8'(i + 1), code[i]);
        rd(8'(i + 1), code[i]);
      end
      wr(8'h00, on);
      @(negedge clk);
      for (i = 0; i < 4; i++) chk("level", exp_lvl(on[i], code[i]), lvl[i]);
    end
    wr(8'h00, 8'h0f);
    wr(8'h05, 8'h01);
    audio = 8'($random(seed));
    wr(8'h01, 8'h5a);
    @(negedge clk);
    chk("audio", audio, lvl[0]);
    rd(8'h01, code[0]);
    wr(8'h05, 8'h00);
    @(negedge clk);
    chk("level", code[0], lvl[0]);
    wr(8'h00, 8'h8f);
    wr(8'h00, 8'h9f);
    @(negedge clk);
    chk("torch", 8'h01, {7'h0, torch_on});
    wr(8'h00, 8'hff);
    @(negedge clk);
    chk("flash", 8'h01, {6'h0, torch_on, flash_on});
    wr(8'h00, 8'hbf);
    @(negedge clk);
    chk("flash", 8'h00, {7'h0, flash_on});
    wr(8'h00, 8'hff);
    flen(n);
    chk("short", 8'(SC), 8'(n));
    rd(8'h06, 8'h04);
    wr(8'h00, 8'hff);
    repeat (3) @(negedge clk);
    chk("rearm", 8'h00, {7'h0, flash_on});
    wr(8'h00, 8'hbf);
    wr(8'h00, 8'hff);
    flen(n);
    chk("short", 8'(SC), 8'(n));
    wr(8'h00, 8'h3f);
    wr(8'h00, 8'h7f);
    flen(n);
    chk("long", 8'(LC), 8'(n));
    // limit shortened in mid-flash cuts at once
    wr(8'h00, 8'h3f);
    wr(8'h00, 8'h7f);
    repeat (30) @(negedge clk);
    wr(8'h00, 8'hff);
    repeat (2) @(negedge clk);
    chk("cut", 8'h00, {7'h0, flash_on});
    rd(8'h06, 8'h04);
    wr(8'h00, 8'h2f);
    for (k = 0; k < 3; k++) begin
      len = 8'h02 + (8'h1f & 8'($random(seed)));
      @(negedge clk) fire = 1'b1;
      @(negedge clk) fire = 1'b0;
      flen(n);
      chk("pin", len, 8'(n));
      repeat (4) @(negedge clk);
    end
    wr(8'h00, 8'h00);
    repeat (4) @(negedge clk);
    stop_test;
  end
endmodule
